// ==== verilog/adcrt_pkg.sv ====
/*
 * Package for the converter result and trigger logic: register word indexes,
 * field positions, reset values and trigger source codes.
 * Assumes a 32-bit AXI4-Lite slave where each register takes one aligned word.
 */
package adcrt_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  // Index constants as printed; byte address is four times the index.
  localparam logic [7:0]  IDX_RESULT_LOW   = 8'h78;
  localparam logic [7:0]  IDX_RESULT_HIGH  = 8'h79;
  localparam logic [7:0]  IDX_CTRL_MAIN    = 8'h7a;
  localparam logic [7:0]  IDX_TRIG_CTRL    = 8'h7b;
  localparam logic [7:0]  IDX_CHAN_SEL     = 8'h7c;
  localparam logic [7:0]  IDX_BUF_DISABLE  = 8'h7e;
  localparam logic [7:0]  IDX_STATUS       = 8'h7f;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int ENABLE_BIT       = 7;
  localparam int AUTO_TRIG_BIT    = 5;
  localparam int DONE_FLAG_BIT    = 4;
  localparam int LEFT_ADJUST_BIT  = 5;
  localparam int TRIG_SRC_MSB     = 2;
  localparam int PIN_BUF_MSB      = 5;

  // ------------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------------
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [9:0]  RESET_RESULT    = 10'h000;
  localparam logic [7:0]  TRIG_CTRL_MASK  = 8'h07;
  localparam logic [7:0]  BUF_DIS_MASK    = 8'h3f;
  localparam logic [7:0]  CTRL_MAIN_MASK  = 8'hef;
  localparam logic [7:0]  CHAN_SEL_MASK   = 8'hef;

  // ------------------------------------------------------------------
  // Trigger sources
  // ------------------------------------------------------------------
  localparam logic [2:0]  TRIG_FREE_RUN   = 3'h0;
  localparam logic [2:0]  TRIG_COMPARATOR = 3'h1;
  localparam logic [2:0]  TRIG_EXT_IRQ0   = 3'h2;
  localparam logic [2:0]  TRIG_T0_CMP_A   = 3'h3;
  localparam logic [2:0]  TRIG_T0_OVF     = 3'h4;
  localparam logic [2:0]  TRIG_T1_CMP_B   = 3'h5;
  localparam logic [2:0]  TRIG_T1_OVF     = 3'h6;
  localparam logic [2:0]  TRIG_T1_CAPTURE = 3'h7;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : adcrt_pkg

// ==== verilog/adcrt_top.sv ====
/*
 * Digital side of the converter: result byte registers with left or right
 * adjust and a read lock, auto-trigger source selection with edge detect,
 * and per-pin input buffer disables, all behind an AXI4-Lite slave.
 * Assumes the analog core reports each finished conversion with a one-cycle
 * pulse and its 10-bit value, and that trigger flags are synchronous levels.
 */
// Register access over AXI4-Lite was decided locally.
//
// Functional notes
// - Result lands in low/high read-only bytes.
// - Left adjust: high=9..2, low[7:6]=1..0.
// - Low-byte read locks results until high read.
// - Right adjust when left-adjust bit clear.
// - Trigger source used only with auto trigger.
// - Start on rising edge of selected flag.
// - Switching from a clear to a set source is an edge.
// - Selecting free running never triggers itself.
// - Codes 0..7 map to eight trigger sources.
// - Six disable bits switch off pin buffers.
// - Disabled pin reads zero in port input.
// - No disable bits for channels 6, 7.
// - Right adjust: high[1:0]=9..8, low=7..0.
// - Left-adjust change acts on readout immediately.
// - Done flag sets on update, write-one clears.
`timescale 1ns/10ps
module adcrt_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_value,
  input  wire logic        conv_busy,
  input  wire logic        comparator_flag,
  input  wire logic        ext_irq0_flag,
  input  wire logic        t0_cmp_a_flag,
  input  wire logic        t0_ovf_flag,
  input  wire logic        t1_cmp_b_flag,
  input  wire logic        t1_ovf_flag,
  input  wire logic        t1_capture_flag,
  input  wire logic [5:0]  pin_raw,
  output      logic        conv_start,
  output      logic        converter_enable,
  output      logic [3:0]  channel_select_bits,
  output      logic [5:0]  pin_buffer_disable_bits,
  output      logic [5:0]  pin_input_gated
);

  // ------------------------------------------------------------------
  // Software-visible state
  // ------------------------------------------------------------------
  logic [7:0] ctrl_main_q;
  logic [7:0] trig_ctrl_q;
  logic [7:0] chan_sel_q;
  logic [7:0] buf_dis_q;
  logic [9:0] conversion_result_q;
  logic       lock_q;
  logic       done_flag_q;
  logic       dropped_q;
  logic       trig_prev_q;

  logic       auto_trigger_enable;
  logic       result_left_adjust;
  logic [2:0] trigger_source_select;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;

  assign converter_enable      = ctrl_main_q[adcrt_pkg::ENABLE_BIT];
  assign auto_trigger_enable   = ctrl_main_q[adcrt_pkg::AUTO_TRIG_BIT];
  assign result_left_adjust    = chan_sel_q[adcrt_pkg::LEFT_ADJUST_BIT];
  assign trigger_source_select = trig_ctrl_q[adcrt_pkg::TRIG_SRC_MSB:0];
  assign channel_select_bits   = chan_sel_q[3:0];
  assign pin_buffer_disable_bits = buf_dis_q[adcrt_pkg::PIN_BUF_MSB:0];
  assign pin_input_gated       = pin_raw & ~pin_buffer_disable_bits;

  // ------------------------------------------------------------------
  // Result presentation
  // ------------------------------------------------------------------
  // Formatting is combinational on the stored value, so a change of adjust
  // takes effect on the very next read.
  always_comb begin
    if (result_left_adjust) begin
      result_high_byte = conversion_result_q[9:2];
      result_low_byte  = {conversion_result_q[1:0], 6'h00};
    end else begin
      result_high_byte = {6'h00, conversion_result_q[9:8]};
      result_low_byte  = conversion_result_q[7:0];
    end
  end

  // ------------------------------------------------------------------
  // Trigger source and edge detect
  // ------------------------------------------------------------------
  logic trig_sel;

  always_comb begin
    unique case (trigger_source_select)
      adcrt_pkg::TRIG_FREE_RUN:   trig_sel = 1'b0;
      adcrt_pkg::TRIG_COMPARATOR: trig_sel = comparator_flag;
      adcrt_pkg::TRIG_EXT_IRQ0:   trig_sel = ext_irq0_flag;
      adcrt_pkg::TRIG_T0_CMP_A:   trig_sel = t0_cmp_a_flag;
      adcrt_pkg::TRIG_T0_OVF:     trig_sel = t0_ovf_flag;
      adcrt_pkg::TRIG_T1_CMP_B:   trig_sel = t1_cmp_b_flag;
      adcrt_pkg::TRIG_T1_OVF:     trig_sel = t1_ovf_flag;
      adcrt_pkg::TRIG_T1_CAPTURE: trig_sel = t1_capture_flag;
    endcase
  end

  // The previous sample holds the multiplexer output, not each source, so a
  // switch from a clear source to a set one shows up as a rising edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sel;
    end
  end

  // Free running restarts on each completion; the code-zero path never
  // raises an edge from the multiplexer, so switching to it cannot start one.
  logic free_run_start;
  assign free_run_start = (trigger_source_select == adcrt_pkg::TRIG_FREE_RUN)
                          && conv_done;

  assign conv_start = converter_enable && auto_trigger_enable
                      && ((trig_sel && !trig_prev_q) || free_run_start);

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic [7:0]  widx;
  logic [7:0]  ridx;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rd_byte;

  function automatic logic [7:0] word_index(input logic [11:0] addr);
    return addr[9:2];
  endfunction : word_index

  function automatic logic known_index(input logic [7:0] idx);
    return idx == adcrt_pkg::IDX_RESULT_LOW || idx == adcrt_pkg::IDX_RESULT_HIGH
        || idx == adcrt_pkg::IDX_CTRL_MAIN  || idx == adcrt_pkg::IDX_TRIG_CTRL
        || idx == adcrt_pkg::IDX_CHAN_SEL   || idx == adcrt_pkg::IDX_BUF_DISABLE
        || idx == adcrt_pkg::IDX_STATUS;
  endfunction : known_index

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;
  assign widx          = word_index(awaddr_q);
  assign wr_hit        = known_index(widx) && (awaddr_q[11:10] == 2'h0);
  assign s_axi_arready = !s_axi_rvalid;
  assign ridx          = word_index(s_axi_araddr);
  assign rd_hit        = known_index(ridx) && (s_axi_araddr[11:10] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= adcrt_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? adcrt_pkg::RESP_OKAY : adcrt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data; other lanes are ignored.
  logic wr_lane0;
  assign wr_lane0 = do_write && wr_hit && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_main_q <= adcrt_pkg::RESET_BYTE;
      trig_ctrl_q <= adcrt_pkg::RESET_BYTE;
      chan_sel_q  <= adcrt_pkg::RESET_BYTE;
      buf_dis_q   <= adcrt_pkg::RESET_BYTE;
    end else if (wr_lane0) begin
      unique case (widx)
        adcrt_pkg::IDX_CTRL_MAIN:   ctrl_main_q <= wdata_q[7:0] & adcrt_pkg::CTRL_MAIN_MASK;
        adcrt_pkg::IDX_TRIG_CTRL:   trig_ctrl_q <= wdata_q[7:0] & adcrt_pkg::TRIG_CTRL_MASK;
        adcrt_pkg::IDX_CHAN_SEL:    chan_sel_q  <= wdata_q[7:0] & adcrt_pkg::CHAN_SEL_MASK;
        adcrt_pkg::IDX_BUF_DISABLE: buf_dis_q   <= wdata_q[7:0] & adcrt_pkg::BUF_DIS_MASK;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (ridx)
      adcrt_pkg::IDX_RESULT_LOW:  rd_byte = result_low_byte;
      adcrt_pkg::IDX_RESULT_HIGH: rd_byte = result_high_byte;
      adcrt_pkg::IDX_CTRL_MAIN:   rd_byte = {ctrl_main_q[7], conv_busy, ctrl_main_q[5],
                                             done_flag_q, ctrl_main_q[3:0]};
      adcrt_pkg::IDX_TRIG_CTRL:   rd_byte = trig_ctrl_q;
      adcrt_pkg::IDX_CHAN_SEL:    rd_byte = chan_sel_q;
      adcrt_pkg::IDX_BUF_DISABLE: rd_byte = buf_dis_q;
      adcrt_pkg::IDX_STATUS:      rd_byte = {6'h00, dropped_q, lock_q};
      default:                    rd_byte = 8'h00;
    endcase
  end

  logic rd_take;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= adcrt_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? adcrt_pkg::RESP_OKAY : adcrt_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Result register, lock and done flag
  // ------------------------------------------------------------------
  logic rd_low;
  logic rd_high;
  assign rd_low  = rd_take && rd_hit && ridx == adcrt_pkg::IDX_RESULT_LOW;
  assign rd_high = rd_take && rd_hit && ridx == adcrt_pkg::IDX_RESULT_HIGH;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else if (rd_high) begin
      lock_q <= 1'b0;
    end else if (rd_low) begin
      lock_q <= 1'b1;
    end
  end

  // A completion in the cycle of the high-byte read still sees the lock and
  // is dropped; the hazard of a torn pair outweighs the lost sample.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_result_q <= adcrt_pkg::RESET_RESULT;
    end else if (conv_done && !lock_q) begin
      conversion_result_q <= conv_value;
    end
  end

  // Sticky record of a dropped completion, cleared by a high-byte read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dropped_q <= 1'b0;
    end else if (conv_done && lock_q) begin
      dropped_q <= 1'b1;
    end else if (rd_high) begin
      dropped_q <= 1'b0;
    end
  end

  logic clr_done;
  assign clr_done = wr_lane0 && widx == adcrt_pkg::IDX_CTRL_MAIN
                    && wdata_q[adcrt_pkg::DONE_FLAG_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag_q <= 1'b0;
    end else if (conv_done && !lock_q) begin
      done_flag_q <= 1'b1;
    end else if (clr_done) begin
      done_flag_q <= 1'b0;
    end
  end

endmodule : adcrt_top

// ==== test/adcrt_props.sv ====
/*
 * Port-level assertions and covers for the converter result and trigger block.
 * Assumes binding into adcrt_top with a free-running aclk and sync aresetn.
 */
`timescale 1ns/10ps
module adcrt_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        conv_start,
  input wire logic        converter_enable,
  input wire logic [5:0]  pin_raw,
  input wire logic [5:0]  pin_buffer_disable_bits,
  input wire logic [5:0]  pin_input_gated
);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_gate_zero: assert property (pin_input_gated == (pin_raw & ~pin_buffer_disable_bits))
    else $error("gated pin input wrong");
  a_start_enable: assert property (conv_start |-> converter_enable)
    else $error("start while converter disabled");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved while waiting");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");

  c_start: cover property (conv_start);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : adcrt_props

bind adcrt_top adcrt_props adcrt_props_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .conv_start(conv_start), .converter_enable(converter_enable), .pin_raw(pin_raw),
  .pin_buffer_disable_bits(pin_buffer_disable_bits), .pin_input_gated(pin_input_gated));

// ==== test/adc_result_and_trigger_logic_test.sv ====
/*
 * Self-checking bench for adcrt_top: register reads and writes queue their expected
 * answer, a watcher compares at each response handshake.
 * Assumes the checker is bound in and one bus transfer runs at a time.
 */
`timescale 1ns/10ps
module adc_result_and_trigger_logic_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, en_out;
  logic        awready, wready, bvalid, arready, rvalid, conv_done, conv_busy, conv_start;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rng;
  logic [1:0]  bresp, rresp;
  logic [9:0]  conv_value, v, w;
  logic [7:1]  flg;
  logic [5:0]  pin_raw, gated, bufdis;
  logic [3:0]  chan;
  logic [7:0]  b;
  logic [33:0] notes[$];
  int          fail_count, total_checks, starts, n;

  adcrt_top adcrt_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_done(conv_done), .conv_value(conv_value), .conv_busy(conv_busy),
    .comparator_flag(flg[1]), .ext_irq0_flag(flg[2]), .t0_cmp_a_flag(flg[3]),
    .t0_ovf_flag(flg[4]), .t1_cmp_b_flag(flg[5]), .t1_ovf_flag(flg[6]),
    .t1_capture_flag(flg[7]), .pin_raw(pin_raw), .conv_start(conv_start),
    .converter_enable(en_out), .channel_select_bits(chan),
    .pin_buffer_disable_bits(bufdis), .pin_input_gated(gated));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Ready is sampled on the falling edge; inputs only move on rising edges,
  // so that value is exactly what the next rising edge sees.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] exp);
    logic aw_hit, w_hit, ar_hit, done;
    notes.push_back(exp);
    done = 1'b0;
    @(posedge aclk);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (int i = 0; i < 50 && !done; i++) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      ar_hit = arvalid && arready;
      done = wr ? (bvalid === 1'b1 && bready) : (rvalid === 1'b1 && rready);
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (ar_hit) arvalid <= 1'b0;
      if (done) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
    if (!done) begin
      fail_count++;
      report_and_stop();
    end
  endtask : bus

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, ad(i), 32'h0, {adcrt_pkg::RESP_OKAY, 24'h0, e});
  endtask : rd

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, ad(i), {24'h0, d}, {adcrt_pkg::RESP_OKAY, 32'h0});
  endtask : wr

  task automatic conv(input logic [9:0] x);
    @(posedge aclk);
    conv_done <= 1'b1;
    conv_value <= x;
    @(posedge aclk);
    conv_done <= 1'b0;
  endtask : conv

  task automatic starts_are(input int e);
    repeat (4) @(posedge aclk);
    check(34'(starts), 34'(e));
  endtask : starts_are

  always @(posedge aclk) begin
    if (conv_start === 1'b1) starts++;
    if ((rvalid === 1'b1 && rready) || (bvalid === 1'b1 && bready)) begin
      check(rvalid ? {rresp, rdata} : {bresp, 32'h0}, notes.pop_front());
    end
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, conv_done, conv_busy} = 7'h0;
    {awaddr, araddr, wdata, conv_value, flg, pin_raw} = '0;
    {fail_count, total_checks, starts} = '0;
    aresetn = 1'b0;
    rng = 32'd89746;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    conv_busy <= 1'b1;
    rd(adcrt_pkg::IDX_CTRL_MAIN, 8'h40);
    conv_busy <= 1'b0;
    rd(adcrt_pkg::IDX_RESULT_LOW, 8'h00);
    rd(adcrt_pkg::IDX_RESULT_HIGH, 8'h00);
    rd(adcrt_pkg::IDX_TRIG_CTRL, 8'h00);
    rd(adcrt_pkg::IDX_BUF_DISABLE, 8'h00);
    bus(1'b0, ad(8'h7d), 32'h0, {adcrt_pkg::RESP_SLVERR, 32'h0});
    for (n = 0; n < 3; n++) begin
      rng = xs(rng);
      v = rng[9:0];
      conv(v);
      rd(adcrt_pkg::IDX_CTRL_MAIN, 8'h10);
      wr(adcrt_pkg::IDX_CTRL_MAIN, 8'h10);
      rd(adcrt_pkg::IDX_CTRL_MAIN, 8'h00);
      rd(adcrt_pkg::IDX_RESULT_LOW, v[7:0]);
      rd(adcrt_pkg::IDX_RESULT_HIGH, {6'h0, v[9:8]});
      wr(adcrt_pkg::IDX_CHAN_SEL, {4'h2, v[3:0]});
      check({30'h0, chan}, {30'h0, v[3:0]});
      rd(adcrt_pkg::IDX_RESULT_LOW, {v[1:0], 6'h0});
      rd(adcrt_pkg::IDX_RESULT_HIGH, v[9:2]);
      wr(adcrt_pkg::IDX_CHAN_SEL, 8'h00);
    end
    w = ~v;
    rd(adcrt_pkg::IDX_RESULT_LOW, v[7:0]);
    conv(w);
    rd(adcrt_pkg::IDX_STATUS, 8'h03);
    rd(adcrt_pkg::IDX_RESULT_HIGH, {6'h0, v[9:8]});
    conv(w);
    rd(adcrt_pkg::IDX_RESULT_LOW, w[7:0]);
    rd(adcrt_pkg::IDX_RESULT_HIGH, {6'h0, w[9:8]});
    for (n = 0; n < 3; n++) begin
      rng = xs(rng);
      b = rng[7:0] & adcrt_pkg::BUF_DIS_MASK;
      wr(adcrt_pkg::IDX_BUF_DISABLE, b);
      pin_raw <= rng[13:8];
      rd(adcrt_pkg::IDX_BUF_DISABLE, b);
      check({28'h0, gated}, {28'h0, rng[13:8] & ~b[5:0]});
      check({28'h0, bufdis}, {28'h0, b[5:0]});
    end
    wr(adcrt_pkg::IDX_CTRL_MAIN, 8'ha0);
    for (n = 1; n < 8; n++) begin
      wr(adcrt_pkg::IDX_TRIG_CTRL, 8'(n));
      @(posedge aclk);
      flg[n] <= 1'b1;
      starts_are(n);
      flg[n] <= 1'b0;
    end
    wr(adcrt_pkg::IDX_TRIG_CTRL, 8'h02);
    @(posedge aclk);
    flg[3] <= 1'b1;
    starts_are(7);
    wr(adcrt_pkg::IDX_TRIG_CTRL, 8'h03);
    starts_are(8);
    conv(v);
    wr(adcrt_pkg::IDX_TRIG_CTRL, 8'h00);
    starts_are(8);
    conv(w);
    starts_are(9);
    flg[3] <= 1'b0;
    wr(adcrt_pkg::IDX_CTRL_MAIN, 8'h80);
    check({33'h0, en_out}, 34'h1);
    wr(adcrt_pkg::IDX_TRIG_CTRL, 8'h01);
    @(posedge aclk);
    flg[1] <= 1'b1;
    starts_are(9);
    flg[1] <= 1'b0;
    wr(adcrt_pkg::IDX_CTRL_MAIN, 8'h20);
    @(posedge aclk);
    flg[1] <= 1'b1;
    starts_are(9);
    report_and_stop();
  end
endmodule : adc_result_and_trigger_logic_test
